//--- logic/pclor_pkg.sv
// Purpose: shared constants for the transceiver control and indicator register block
// Assumes: 100 MHz pclk, APB with 32-bit data
// Notes: register indices are kept as printed; byte address is four times the index
`default_nettype none
package pclor_pkg;
    // register indices and byte addresses
    localparam logic [5:0] IDX_LED_OVERRIDE = 6'h18;
    localparam logic [5:0] IDX_XCVR_CTRL = 6'h19;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h1C;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h1D;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_LED_OVERRIDE = {IDX_LED_OVERRIDE, 2'b00};
    localparam logic [7:0] ADDR_XCVR_CTRL = {IDX_XCVR_CTRL, 2'b00};
    localparam logic [7:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // led_override_control fields
    localparam int LED_OVR_EN_BIT = 4;
    localparam int LED_FORCE_BIT = 1;
    localparam logic LED_OVR_EN_RST = 1'b0;
    localparam logic LED_FORCE_RST = 1'b0;

    // transceiver_function_control fields
    localparam int XC_AUTO_X_BIT = 15;
    localparam int XC_FORCE_X_BIT = 14;
    localparam int XC_PAUSE_RX_BIT = 13;
    localparam int XC_PAUSE_TX_BIT = 12;
    localparam int XC_INJECT_BIT = 11;
    localparam int XC_PATTERN_BIT = 10;
    localparam int XC_RESULT_BIT = 9;
    localparam int XC_RUN_BIT = 8;
    localparam int XC_BYPASS_BIT = 7;
    localparam int XC_MODE_BIT = 5;
    localparam int XC_ADDR_LSB = 0;
    localparam int XC_ADDR_W = 5;
    localparam logic XC_FORCE_X_RST = 1'b0;
    localparam logic XC_PATTERN_RST = 1'b0;
    localparam logic XC_RUN_RST = 1'b0;
    localparam logic XC_BYPASS_RST = 1'b0;

    // interrupt status / mask fields
    localparam int IRQ_W = 2;
    localparam int IRQ_LINK_CHG_BIT = 0;
    localparam int IRQ_SELFTEST_FAIL_BIT = 1;

    // activity stretch time
    localparam int CLK_MHZ = 100;
    localparam int STRETCH_TIME_US = 50000;
    localparam int STRETCH_CYCLES = STRETCH_TIME_US * CLK_MHZ;

    // indicator modes
    typedef enum logic {
        PCLOR_MODE_TWO,
        PCLOR_MODE_ONE
    } pclor_mode_e;
endpackage
`default_nettype wire

//--- logic/pclor_pause.sv
// Purpose: full-duplex pause resolution from local and partner ability bits
// Assumes: ability inputs are {asymmetric direction, pause}
// Notes: outputs are registered
`timescale 1ns/1ps
`default_nettype none
module pclor_pause (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] local_ability,
    input wire logic [1:0] partner_ability,
    input wire logic full_duplex,
    output logic pause_tx,
    output logic pause_rx
);
    logic lp;
    logic la;
    logic pp;
    logic pa;
    logic tx_nxt;
    logic rx_nxt;

    ////////////////////////////////////////////////////////////////////////
    // standard resolution; half duplex never enables pause
    assign lp = local_ability[0];
    assign la = local_ability[1];
    assign pp = partner_ability[0];
    assign pa = partner_ability[1];
    assign tx_nxt = full_duplex & ((lp & pp) | (~lp & la & pp & pa));
    assign rx_nxt = full_duplex & ((lp & pp) | (lp & la & ~pp & pa));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_tx <= 1'b0;
            pause_rx <= 1'b0;
        end else begin
            pause_tx <= tx_nxt;
            pause_rx <= rx_nxt;
        end
    end
endmodule
`default_nettype wire

//--- logic/pclor_stretch.sv
// Purpose: stretch short indicator pulses to a minimum visible time
// Assumes: pulse input synchronous to pclk
// Notes: bypass passes raw through one flop
`timescale 1ns/1ps
`default_nettype none
module pclor_stretch #(
    parameter int CYCLES = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw,
    input wire logic bypass,
    output logic stretched
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] RELOAD = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // retrigger on every raw high cycle, hold until the count runs out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            stretched <= 1'b0;
        end else if (bypass) begin
            cnt_r <= '0;
            stretched <= raw;
        end else if (raw) begin
            cnt_r <= RELOAD;
            stretched <= 1'b1;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end else begin
            stretched <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- logic/pclor_top.sv
// Purpose: indicator override and transceiver function control registers behind APB
// Assumes: all inputs synchronous to pclk; straps stable around reset release
// Notes: zero-wait-state after one setup cycle; read data sampled in the setup cycle
//
// Overview of operation
// R1 - reserved bits in both registers ignore writes and read back zero
// R2 - override enable drives link indicator from force value, otherwise normal indication
// R3 - force value bit holds the override level, resets to zero, read/write
// R4 - override register reads stored bits, never the live indicator level
// R5 - auto crossover enable bit, strap default, enables crossover during negotiation
// R6 - software should clear auto crossover when negotiation is disabled
// R7 - crossover force bit swaps pairs when one, default zero
// R8 - receive pause result from ability bits, only in full duplex
// R9 - transmit pause result from ability bits, only in full duplex
// R10 - writing one to inject bit emits one error, then self-clears
// R11 - pattern select: one picks fifteen-stage, zero picks nine-stage sequence
// R12 - run bit starts/stops self-test; result latches fail, clears on stop
// R13 - stretch bypass makes indicators follow raw status directly
// R14 - mode bit, strap default: one selects mode 1, zero mode 2
// R15 - five-bit port address field, strap default, read/write
// R16 - strap fields capture their pins after reset release, kept until rewritten
`timescale 1ns/1ps
`default_nettype none
module pclor_top
    import pclor_pkg::*;
#(
    parameter int STRETCH_LEN = pclor_pkg::STRETCH_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [pclor_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_good,
    input wire logic activity,
    input wire logic [1:0] local_ability,
    input wire logic [1:0] partner_ability,
    input wire logic full_duplex,
    input wire logic selftest_error,
    input wire logic strap_auto_crossover,
    input wire logic strap_mode_one,
    input wire logic [4:0] strap_port_address,
    output logic link_indicator_out,
    output logic activity_indicator_out,
    output logic auto_crossover_enable,
    output logic crossover_force,
    output logic pause_rx_enable,
    output logic pause_tx_enable,
    output logic selftest_run,
    output logic selftest_pattern_select,
    output logic selftest_error_inject,
    output logic selftest_result,
    output logic indicator_stretch_bypass,
    output logic indicator_mode_select,
    output logic [4:0] port_mgmt_address,
    output logic irq
);
    import pclor_pkg::*;

    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic hit_led;
    logic hit_xc;
    logic hit_sts;
    logic hit_msk;
    logic mapped;
    logic [31:0] rd_mux;
    logic [15:0] led_word;
    logic [15:0] xc_word;
    logic indicator_override_enable_r;
    logic indicator_force_value_r;
    logic strap_loaded_r;
    logic fail_latch_r;
    logic link_prev_r;
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] rd_sts_snap_r;
    logic act_stretched;
    logic link_stretched;
    logic link_normal;
    logic pause_tx_w;
    logic pause_rx_w;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done = access_done & pwrite;
    assign rd_done = access_done & ~pwrite;
    assign hit_led = (paddr == ADDR_LED_OVERRIDE);
    assign hit_xc = (paddr == ADDR_XCVR_CTRL);
    assign hit_sts = (paddr == ADDR_IRQ_STATUS);
    assign hit_msk = (paddr == ADDR_IRQ_MASK);
    assign mapped = hit_led | hit_xc | hit_sts | hit_msk;

    // stored bits only, never the live pin
    always_comb begin
        led_word = 16'h0000; // reserved positions stay zero [R1]
        led_word[LED_OVR_EN_BIT] = indicator_override_enable_r;
        led_word[LED_FORCE_BIT] = indicator_force_value_r; // [R4]
    end

    // bit 6 stays zero
    always_comb begin
        xc_word = 16'h0000; // [R1]
        xc_word[XC_AUTO_X_BIT] = auto_crossover_enable;
        xc_word[XC_FORCE_X_BIT] = crossover_force;
        xc_word[XC_PAUSE_RX_BIT] = pause_rx_enable;
        xc_word[XC_PAUSE_TX_BIT] = pause_tx_enable;
        xc_word[XC_INJECT_BIT] = selftest_error_inject;
        xc_word[XC_PATTERN_BIT] = selftest_pattern_select;
        xc_word[XC_RESULT_BIT] = selftest_result;
        xc_word[XC_RUN_BIT] = selftest_run;
        xc_word[XC_BYPASS_BIT] = indicator_stretch_bypass;
        xc_word[XC_MODE_BIT] = indicator_mode_select;
        xc_word[XC_ADDR_LSB +: XC_ADDR_W] = port_mgmt_address;
    end

    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_led) begin
            rd_mux = {16'h0000, led_word};
        end else if (hit_xc) begin
            rd_mux = {16'h0000, xc_word};
        end else if (hit_sts) begin
            rd_mux = {{(32-IRQ_W){1'b0}}, irq_status_r};
        end else if (hit_msk) begin
            rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer: data and ready are set up in the setup cycle, so the
    // access phase always completes at its first edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h00000000 : rd_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // only status bits the read returned get cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_sts_snap_r <= '0;
        end else if (setup_phase) begin
            rd_sts_snap_r <= (hit_sts & ~pwrite) ? irq_status_r : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator override register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indicator_override_enable_r <= LED_OVR_EN_RST;
            indicator_force_value_r <= LED_FORCE_RST; // [R3]
        end else if (wr_done && hit_led) begin
            indicator_override_enable_r <= pwdata[LED_OVR_EN_BIT];
            indicator_force_value_r <= pwdata[LED_FORCE_BIT]; // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain read/write controls of the function register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crossover_force <= XC_FORCE_X_RST;
            selftest_pattern_select <= XC_PATTERN_RST;
            selftest_run <= XC_RUN_RST;
            indicator_stretch_bypass <= XC_BYPASS_RST;
        end else if (wr_done && hit_xc) begin
            crossover_force <= pwdata[XC_FORCE_X_BIT]; // [R7]
            selftest_pattern_select <= pwdata[XC_PATTERN_BIT]; // [R11]
            selftest_run <= pwdata[XC_RUN_BIT]; // [R12]
            indicator_stretch_bypass <= pwdata[XC_BYPASS_BIT]; // [R13]
        end
    end

    // strap fields: constant reset, pins caught at the
    // first edge after release; a write later replaces them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_loaded_r <= 1'b0;
            auto_crossover_enable <= 1'b0;
            indicator_mode_select <= 1'b0;
            port_mgmt_address <= 5'h00;
        end else if (!strap_loaded_r) begin
            strap_loaded_r <= 1'b1; // [R16]
            auto_crossover_enable <= strap_auto_crossover; // [R5]
            indicator_mode_select <= strap_mode_one; // [R14]
            port_mgmt_address <= strap_port_address; // [R15]
        end else if (wr_done && hit_xc) begin
            // software clears this while negotiation is off
            auto_crossover_enable <= pwdata[XC_AUTO_X_BIT]; // [R5]
            indicator_mode_select <= pwdata[XC_MODE_BIT]; // [R14]
            port_mgmt_address <= pwdata[XC_ADDR_LSB +: XC_ADDR_W]; // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error inject: a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            selftest_error_inject <= 1'b0;
        end else begin
            selftest_error_inject <= wr_done & hit_xc & pwdata[XC_INJECT_BIT]; // [R10]
        end
    end

    // fail is sticky until the test stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_latch_r <= 1'b0;
        end else if (!selftest_run) begin
            fail_latch_r <= 1'b0; // [R12]
        end else if (selftest_error) begin
            fail_latch_r <= 1'b1; // [R12]
        end
    end

    // pass shows only while running with no error seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            selftest_result <= 1'b0;
        end else begin
            selftest_result <= selftest_run & ~fail_latch_r & ~selftest_error; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pause resolution
    pclor_pause u_pause (
        .pclk(pclk),
        .presetn(presetn),
        .local_ability(local_ability),
        .partner_ability(partner_ability),
        .full_duplex(full_duplex),
        .pause_tx(pause_tx_w),
        .pause_rx(pause_rx_w)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_rx_enable <= 1'b0;
            pause_tx_enable <= 1'b0;
        end else begin
            pause_rx_enable <= pause_rx_w; // [R8]
            pause_tx_enable <= pause_tx_w; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators: activity is stretched so short frames stay visible;
    // the bypass trades visibility for exact timing
    pclor_stretch #(
        .CYCLES(STRETCH_LEN)
    ) u_act_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .raw(activity),
        .bypass(indicator_stretch_bypass), // [R13]
        .stretched(act_stretched)
    );

    pclor_stretch #(
        .CYCLES(STRETCH_LEN)
    ) u_link_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .raw(link_good),
        .bypass(indicator_stretch_bypass), // [R13]
        .stretched(link_stretched)
    );

    // mode 1: pure link; mode 2: link blinks off on activity
    always_comb begin
        if (indicator_mode_select == PCLOR_MODE_ONE) begin
            link_normal = link_stretched; // [R14]
        end else begin
            link_normal = link_stretched & ~act_stretched;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_indicator_out <= 1'b0;
            activity_indicator_out <= 1'b0;
        end else begin
            link_indicator_out <= indicator_override_enable_r ? indicator_force_value_r : link_normal; // [R2]
            activity_indicator_out <= act_stretched;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: events set sticky bits, a read clears what it returned,
    // and a new event in the clearing cycle survives
    assign irq_events[IRQ_LINK_CHG_BIT] = link_good ^ link_prev_r;
    assign irq_events[IRQ_SELFTEST_FAIL_BIT] = selftest_run & selftest_error & ~fail_latch_r;
    assign irq_clear = rd_done ? rd_sts_snap_r : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_prev_r <= 1'b0;
        end else begin
            link_prev_r <= link_good;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= '0;
        end else if (wr_done && hit_msk) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    // level output, registered on the same edge as the status bits, from their next value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status_r & ~irq_clear | irq_events) & irq_mask_r);
        end
    end
endmodule
`default_nettype wire

//--- test/pclor_top_props.sv
// Purpose: port-level checker of pclor_top
// Assumes: single pclk domain, presetn async active low
// Notes: bound to pclor_top below
`timescale 1ns/1ps
`default_nettype none
module pclor_props
    import pclor_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [pclor_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [1:0] local_ability,
    input wire logic [1:0] partner_ability,
    input wire logic full_duplex,
    input wire logic selftest_error,
    input wire logic strap_auto_crossover,
    input wire logic strap_mode_one,
    input wire logic [4:0] strap_port_address,
    input wire logic auto_crossover_enable,
    input wire logic crossover_force,
    input wire logic pause_rx_enable,
    input wire logic pause_tx_enable,
    input wire logic selftest_run,
    input wire logic selftest_pattern_select,
    input wire logic selftest_error_inject,
    input wire logic selftest_result,
    input wire logic indicator_stretch_bypass,
    input wire logic indicator_mode_select,
    input wire logic [4:0] port_mgmt_address
);
    logic [1:0] rst_cnt;
    logic [31:0] wd_q;
    // expected pause resolution
    wire logic lp = local_ability[0];
    wire logic la = local_ability[1];
    wire logic pp = partner_ability[0];
    wire logic pa = partner_ability[1];
    wire logic rx_exp = full_duplex & (lp & pp | lp & la & ~pp & pa);
    wire logic tx_exp = full_duplex & (lp & pp | ~lp & la & pp & pa);
    wire logic xc_wr = psel & penable & pready & pwrite & (paddr == ADDR_XCVR_CTRL);
    // edges since reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= 2'h0;
        end else if (rst_cnt != 2'h3) begin
            rst_cnt <= rst_cnt + 2'h1;
        end
    end
    // write data of the last edge
    always_ff @(posedge pclk) begin
        wd_q <= pwdata;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // inputs steady for three edges
    property p_pause_rx;
        $stable({local_ability, partner_ability, full_duplex})[*3] |-> pause_rx_enable == rx_exp;
    endproperty
    a_pause_rx: assert property (p_pause_rx) else $error("pause rx mismatch");
    property p_pause_tx;
        $stable({local_ability, partner_ability, full_duplex})[*3] |-> pause_tx_enable == tx_exp;
    endproperty
    a_pause_tx: assert property (p_pause_tx) else $error("pause tx mismatch");
    property p_inject_pulse;
        selftest_error_inject |=> !selftest_error_inject;
    endproperty
    a_inject_pulse: assert property (p_inject_pulse) else $error("inject wider than one cycle");
    property p_inject_cause;
        selftest_error_inject |-> $past(xc_wr) && wd_q[XC_INJECT_BIT];
    endproperty
    a_inject_cause: assert property (p_inject_cause) else $error("inject without write");
    property p_fail_latch;
        selftest_run && $fell(selftest_result) |=> !selftest_result;
    endproperty
    a_fail_latch: assert property (p_fail_latch) else $error("fail not latched");
    property p_err_fail;
        selftest_run ##1 (selftest_run && selftest_error) |-> ##[1:2] !selftest_result;
    endproperty
    a_err_fail: assert property (p_err_fail) else $error("error did not fail");
    property p_stop_clear;
        !selftest_run [*2] |-> !selftest_result;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("result set while stopped");
    property p_ctrl_mirror;
        xc_wr |=> port_mgmt_address == wd_q[4:0] && indicator_mode_select == wd_q[XC_MODE_BIT]
            && auto_crossover_enable == wd_q[XC_AUTO_X_BIT] && crossover_force == wd_q[XC_FORCE_X_BIT]
            && selftest_pattern_select == wd_q[XC_PATTERN_BIT] && selftest_run == wd_q[XC_RUN_BIT]
            && indicator_stretch_bypass == wd_q[XC_BYPASS_BIT];
    endproperty
    a_ctrl_mirror: assert property (p_ctrl_mirror) else $error("control field mismatch");
    property p_strap_load;
        rst_cnt == 2'h1 |-> port_mgmt_address == strap_port_address
            && indicator_mode_select == strap_mode_one && auto_crossover_enable == strap_auto_crossover;
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not loaded");
    c_inject: cover property (selftest_error_inject);
    c_fail: cover property (selftest_run && $fell(selftest_result));
    c_pause: cover property (pause_rx_enable && pause_tx_enable);
endmodule
bind pclor_top pclor_props props_u (.*);
`default_nettype wire

//--- test/phy_control_led_override_regs_tb_top.sv
// Purpose: directed bench of pclor_top
// Assumes: APB slave answers one cycle after setup
// Notes: stretch shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module phy_control_led_override_regs_tb_top;
    import pclor_pkg::*;
    localparam int SLEN = 8;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, link_indicator_out, activity_indicator_out;
    logic link_good = 0, activity = 0, full_duplex = 0, selftest_error = 0;
    logic [1:0] local_ability = 2'h0, partner_ability = 2'h0;
    logic strap_auto_crossover = 1, strap_mode_one = 1;
    logic [4:0] strap_port_address = 5'h15, port_mgmt_address;
    logic auto_crossover_enable, crossover_force, pause_rx_enable, pause_tx_enable;
    logic selftest_run, selftest_pattern_select, selftest_error_inject, selftest_result;
    logic indicator_stretch_bypass, indicator_mode_select;
    int num_errors = 0, comparisons = 0, inj_cnt = 0, cyc = 0;
    pclor_top #(.STRETCH_LEN(SLEN)) dut_u (.*);
    // free-running clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    // hang guard and inject pulse counter
    always @(posedge pclk) begin
        cyc++;
        if (selftest_error_inject === 1'b1) inj_cnt++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        lerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdc(ADDR_LED_OVERRIDE, 32'h0);
        rdc(ADDR_XCVR_CTRL, 32'h8035);
        wr(ADDR_LED_OVERRIDE, 32'hFFFFFFFF);
        rdc(ADDR_LED_OVERRIDE, 32'h12);
        chk(link_indicator_out, 1);
        link_good <= 1;
        wr(ADDR_LED_OVERRIDE, 32'h10);
        rdc(ADDR_LED_OVERRIDE, 32'h10);
        chk(link_indicator_out, 0);
        wr(ADDR_LED_OVERRIDE, 32'h0);
        wait_n(4);
        chk(link_indicator_out, 1);
        wr(ADDR_XCVR_CTRL, 32'hFFFFFFFF);
        chk({auto_crossover_enable, crossover_force, selftest_pattern_select, selftest_run,
            indicator_stretch_bypass, indicator_mode_select, port_mgmt_address}, 32'h7FF);
        rdc(ADDR_XCVR_CTRL, 32'hC7BF);
        chk(inj_cnt, 1);
        wr(ADDR_XCVR_CTRL, 32'h0);
        rdc(ADDR_XCVR_CTRL, 32'h0);
    endtask
    // every ability and duplex combination
    task automatic t_pause();
        logic rx, tx;
        for (int i = 0; i < 32; i++) begin
            {full_duplex, local_ability, partner_ability} <= i[4:0];
            wait_n(4);
            rx = i[4] & (i[2] & i[0] | i[2] & i[3] & ~i[0] & i[1]);
            tx = i[4] & (i[2] & i[0] | ~i[2] & i[3] & i[0] & i[1]);
            chk({pause_rx_enable, pause_tx_enable}, {30'h0, rx, tx});
            rdc(ADDR_XCVR_CTRL, {18'h0, rx, tx, 12'h0});
        end
        full_duplex <= 0;
    endtask
    task automatic t_selftest();
        wr(ADDR_IRQ_MASK, 32'h3);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        wr(ADDR_XCVR_CTRL, 32'h100);
        wait_n(3);
        rdc(ADDR_XCVR_CTRL, 32'h300);
        selftest_error <= 1;
        @(posedge pclk);
        selftest_error <= 0;
        wait_n(3);
        rdc(ADDR_XCVR_CTRL, 32'h100);
        chk(irq, 1);
        rdc(ADDR_IRQ_STATUS, 32'h2);
        wait_n(2);
        chk(irq, 0);
        wr(ADDR_XCVR_CTRL, 32'h900);
        rdc(ADDR_XCVR_CTRL, 32'h100);
        chk(inj_cnt, 2);
        wr(ADDR_XCVR_CTRL, 32'h0);
        rdc(ADDR_XCVR_CTRL, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h2);
        link_good <= 0;
        wait_n(4);
        chk(irq, 0);
        rdc(ADDR_IRQ_STATUS, 32'h1);
        apb(1'b0, 8'h68, 32'h0);
        chk(lerr, 1);
        chk(rd, 0);
    endtask
    // stretching on and off, then mode 1 ignores activity
    task automatic t_lamps();
        activity <= 1;
        @(posedge pclk);
        activity <= 0;
        wait_n(5);
        chk(activity_indicator_out, 1);
        wait_n(12);
        chk(activity_indicator_out, 0);
        wr(ADDR_XCVR_CTRL, 32'h80);
        activity <= 1;
        @(posedge pclk);
        activity <= 0;
        wait_n(4);
        chk(activity_indicator_out, 0);
        wr(ADDR_XCVR_CTRL, 32'hA0);
        link_good <= 1;
        activity <= 1;
        wait_n(4);
        chk(link_indicator_out, 1);
        activity <= 0;
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // reset, then scenarios
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_pause();
        t_selftest();
        t_lamps();
        give_verdict();
    end
endmodule
`default_nettype wire
